// >>> rtl/sram_host.sv
// static memory host: sequences reads and byte-lane writes on the memory pins
`timescale 1ns/1ps
module sram_host
	import sram_host_pkg::*;
#(
	parameter int AW = ADDR_WIDTH,
	parameter int DW = DATA_WIDTH
) (
	// clock and reset
	input  wire logic          core_clk,
	input  wire logic          rst_n,
	// user request side
	input  wire sram_req_type  req,
	input  wire logic          req_valid,
	output logic               req_ready,
	output logic [DW-1:0]      rdata,
	output logic               rdata_valid,
	// memory pins
	output sram_ctrl_type      pins,
	input  wire logic [DW-1:0] data_in,
	output logic [DW-1:0]      data_out,
	output logic [1:0]         data_oe_n
);

	// =====================================================
	// state
	typedef enum logic [2:0] {
		IDLE      = 3'b000,
		RD_WAIT   = 3'b001,
		RD_TURN   = 3'b010,
		WR_PULSE  = 3'b011,
		WR_END    = 3'b100
	} state_type;

	state_type            state, next_state;
	logic [CNT_WIDTH-1:0] cnt, next_cnt;
	sram_ctrl_type        next_pins;
	logic [DW-1:0]        next_data_out, next_rdata;
	logic [1:0]           next_data_oe_n;
	logic                 next_req_ready, next_rdata_valid;

	// =====================================================
	// sequencing
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_pins = pins;
		next_data_out = data_out;
		next_data_oe_n = data_oe_n;
		next_rdata = rdata;
		next_rdata_valid = 1'b0;
		next_req_ready = 1'b0;
		unique case (state)
			IDLE: begin
				// lanes change only together with the selects, never while deselected
				next_pins = CTRL_IDLE;
				next_pins.addr = pins.addr;
				next_data_oe_n = 2'b11;
				next_req_ready = 1'b1;
				if (req_valid && req_ready) begin
					next_req_ready = 1'b0;
					next_pins.addr = req.addr[AW-1:0];
					next_pins.chip_select_low_active = 1'b0;
					next_pins.chip_select_high_active = 1'b1;
					next_pins.upper_lane_enable_n = ~req.lanes[1];
					next_pins.lower_lane_enable_n = ~req.lanes[0];
					if (req.write) begin
						// strobe, selects, lanes and data all start together
						next_pins.write_strobe_n = 1'b0;
						next_data_out = req.wdata;
						next_data_oe_n = ~req.lanes;
						next_cnt = CNT_WIDTH'(WRITE_PULSE_CYC - 1);
						next_state = WR_PULSE;
					end else begin
						// strobe stays high through the whole read
						next_pins.output_enable_n = 1'b0;
						next_cnt = CNT_WIDTH'(READ_WAIT_CYC - 1);
						next_state = RD_WAIT;
					end
				end
			end
			RD_WAIT: begin
				// wait covers address-to-data and enable-to-data
				if (cnt == '0) begin
					next_rdata = data_in;
					next_rdata_valid = 1'b1;
					next_pins = CTRL_IDLE;
					next_pins.addr = pins.addr;
					next_cnt = CNT_WIDTH'(TURN_CYC);
					next_state = RD_TURN;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			RD_TURN: begin
				// memory needs time to float before anyone drives again
				if (cnt == '0) begin
					next_state = IDLE;
					next_req_ready = 1'b1;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			WR_PULSE: begin
				// pulse of 40 ns covers 35 ns select, lane and address setup
				if (cnt == '0) begin
					// strobe alone terminates; data and address held past that edge
					next_pins.write_strobe_n = 1'b1;
					next_state = WR_END;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			WR_END: begin
				// total cycle 60 ns satisfies the 45 ns minimum
				next_pins = CTRL_IDLE;
				next_pins.addr = pins.addr;
				next_data_oe_n = 2'b11;
				next_req_ready = 1'b1;
				next_state = IDLE;
			end
			default: begin
				next_state = IDLE;
				next_pins = CTRL_IDLE;
				next_data_oe_n = 2'b11;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state <= IDLE;
			cnt <= '0;
			pins <= CTRL_IDLE;
			data_out <= '0;
			data_oe_n <= 2'b11;
			rdata <= '0;
			rdata_valid <= 1'b0;
			req_ready <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			pins <= next_pins;
			data_out <= next_data_out;
			data_oe_n <= next_data_oe_n;
			rdata <= next_rdata;
			rdata_valid <= next_rdata_valid;
			req_ready <= next_req_ready;
		end
	end

endmodule

// >>> rtl/sram_host_pkg.sv
// package: pin timing, command and pin group types for the static memory host
package sram_host_pkg;

	// =====================================================
	// geometry
	localparam int ADDR_WIDTH = 20;
	localparam int DATA_WIDTH = 16;
	localparam int CLK_PERIOD_NS = 20;

	// =====================================================
	// timing in ns, as printed
	localparam int READ_CYCLE_NS = 45;
	localparam int ADDR_TO_DATA_NS = 45;
	localparam int OE_TO_DATA_NS = 22;
	localparam int OE_HIGH_Z_NS = 18;
	localparam int WRITE_CYCLE_NS = 45;
	localparam int WRITE_PULSE_NS = 35;
	localparam int DATA_SETUP_NS = 25;
	localparam int ADDR_HOLD_NS = 0;
	localparam int DATA_HOLD_NS = 0;

	// =====================================================
	// derived cycle counts, least times rounded up (read wait one cycle more), at least one cycle
	localparam int READ_WAIT_CYC =
		(ADDR_TO_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TURN_CYC = (OE_HIGH_Z_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_WIDTH = 4;

	// =====================================================
	// pin groups
	typedef struct packed {
		logic [ADDR_WIDTH-1:0] addr;
		logic                  chip_select_low_active;
		logic                  chip_select_high_active;
		logic                  write_strobe_n;
		logic                  output_enable_n;
		logic                  upper_lane_enable_n;
		logic                  lower_lane_enable_n;
	} sram_ctrl_type;

	typedef struct packed {
		logic                  write;
		logic [1:0]            lanes;
		logic [ADDR_WIDTH-1:0] addr;
		logic [DATA_WIDTH-1:0] wdata;
	} sram_req_type;

	localparam sram_ctrl_type CTRL_IDLE = '{
		addr: '0, chip_select_low_active: 1'b1, chip_select_high_active: 1'b0,
		write_strobe_n: 1'b1, output_enable_n: 1'b1,
		upper_lane_enable_n: 1'b1, lower_lane_enable_n: 1'b1};

endpackage

// >>> tb/sram_host_monitor.sv
// checker: pin sequencing of the static memory host
`timescale 1ns/1ps
module sram_host_monitor
	import sram_host_pkg::*;
(
	input wire logic                  core_clk,
	input wire logic                  rst_n,
	input wire logic                  rdata_valid,
	input wire sram_ctrl_type         pins,
	input wire logic [DATA_WIDTH-1:0] data_out,
	input wire logic [1:0]            data_oe_n
);
	wire       sel = !pins.chip_select_low_active && pins.chip_select_high_active;
	wire [1:0] ln  = {pins.upper_lane_enable_n, pins.lower_lane_enable_n};
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// ==========
	// assertions
	a_drive_when_quiet: assert property (data_oe_n != 2'h3 |-> sel && pins.output_enable_n)
		else $error("host drives while memory may drive");
	a_read_strobe_high: assert property (!pins.output_enable_n |-> pins.write_strobe_n)
		else $error("strobe low during read");
	a_write_selected: assert property (!pins.write_strobe_n |-> sel)
		else $error("strobe low while deselected");
	a_write_lanes_driven: assert property (!pins.write_strobe_n |-> data_oe_n == ln)
		else $error("driven lanes differ from enabled lanes");
	a_strobe_width: assert property ($fell(pins.write_strobe_n) |-> !pins.write_strobe_n [*2])
		else $error("write pulse too short");
	a_write_end_hold: assert property ($rose(pins.write_strobe_n) |->
		sel && $stable(pins.addr) && $stable(data_out))
		else $error("address or data moved at write end");
	a_idle_lanes_still: assert property (!sel && !$past(sel) |-> $stable(ln))
		else $error("lane enables toggled while deselected");
	a_read_answer: assert property ($fell(pins.output_enable_n) |-> ##4 rdata_valid)
		else $error("read data not returned in time");
	c_read_done: cover property (rdata_valid);
	c_write_done: cover property ($rose(pins.write_strobe_n));
	c_upper_only: cover property (!pins.write_strobe_n && ln == 2'h1);
endmodule

// >>> tb/sram_host_tb.sv
// testbench: table of accesses through the host to a memory model
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED %0t got %h", $time, a); end end
module sram_host_tb;
	import sram_host_pkg::*;
	logic          core_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_ready, rdata_valid;
	sram_req_type  req = '0;
	logic [15:0]   rdata, data_in, data_out;
	logic [1:0]    data_oe_n;
	sram_ctrl_type pins;
	int            error_cnt = 0, total_checks = 0;
	// read rows carry the expected word in the data field
	sram_req_type  rows [8] = '{
		{1'b1, 2'h3, 20'h00005, 16'h1234}, {1'b0, 2'h3, 20'h00005, 16'h1234},
		{1'b1, 2'h1, 20'h00005, 16'h00AB}, {1'b1, 2'h2, 20'h00005, 16'hCD00},
		{1'b1, 2'h0, 20'h00005, 16'hFFFF}, {1'b0, 2'h3, 20'h00005, 16'hCDAB},
		{1'b1, 2'h3, 20'hFFFFF, 16'h5A5A}, {1'b0, 2'h2, 20'hFFFFF, 16'h5A5A}};
	always #10 core_clk = ~core_clk;
	sram_host uut (.core_clk, .rst_n, .req, .req_valid, .req_ready, .rdata, .rdata_valid,
		.pins, .data_in, .data_out, .data_oe_n);
	sram_model mem (.core_clk, .pins, .data_out, .data_in);
	// ==========
	// tasks
	task automatic run(input sram_req_type r);
		int          n;
		logic [15:0] m;
		m = {{8{r.lanes[1]}}, {8{r.lanes[0]}}};
		req = r;
		req_valid = 1'b1;
		n = 0;
		while (req_ready !== 1'b1 && n < 50) begin @(negedge core_clk); n++; end
		`CHK(req_ready, 1'b1)
		@(negedge core_clk);
		req_valid = 1'b0;
		n = 0;
		while (!r.write && rdata_valid !== 1'b1 && n < 20) begin @(negedge core_clk); n++; end
		if (!r.write) `CHK({rdata_valid, rdata & m}, {1'b1, r.wdata & m})
	endtask
	task tally_and_finish;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ==========
	// sequence
	initial begin
		repeat (8) @(negedge core_clk);
		`CHK({pins, data_oe_n, req_ready}, {CTRL_IDLE, 2'h3, 1'b0})
		rst_n = 1'b1;
		foreach (rows[i]) run(rows[i]);
		// reset in mid-read must park the pins at the next clock edge
		req = rows[1];
		req_valid = 1'b1;
		repeat (3) @(negedge core_clk);
		rst_n = 1'b0;
		req_valid = 1'b0;
		@(negedge core_clk);
		`CHK({pins, data_oe_n}, {CTRL_IDLE, 2'h3})
		rst_n = 1'b1;
		run(rows[5]);
		tally_and_finish;
	end
	initial begin
		#20000;
		error_cnt++;
		tally_and_finish;
	end
endmodule
bind sram_host sram_host_monitor chk (.core_clk, .rst_n, .rdata_valid, .pins, .data_out,
	.data_oe_n);

// >>> tb/sram_model.sv
// memory model: byte-lane static memory answering the host pins
`timescale 1ns/1ps
module sram_model
	import sram_host_pkg::*;
(
	input  wire logic          core_clk,
	input  wire sram_ctrl_type pins,
	input  wire logic [15:0]   data_out,
	output logic [15:0]        data_in
);
	logic [15:0] mem [256];
	logic [15:0] junk = 16'hA5C3;
	logic        sel;
	logic [7:0]  a;
	// ==========
	// array
	assign sel = !pins.chip_select_low_active && pins.chip_select_high_active;
	assign a = pins.addr[7:0];
	// floating lanes toggle so stale data never looks good
	always @(posedge core_clk) junk <= ~junk;
	always @(posedge pins.write_strobe_n) begin
		if (sel && !pins.lower_lane_enable_n) mem[a][7:0] = data_out[7:0];
		if (sel && !pins.upper_lane_enable_n) mem[a][15:8] = data_out[15:8];
	end
	always_comb begin
		data_in = junk;
		if (sel && pins.write_strobe_n && !pins.output_enable_n) begin
			if (!pins.lower_lane_enable_n) data_in[7:0] = mem[a][7:0];
			if (!pins.upper_lane_enable_n) data_in[15:8] = mem[a][15:8];
		end
	end
endmodule
